// >>> core/preamble_tolerance_decode.sv
`timescale 1ns/1ps
`default_nettype none

module preamble_tolerance_decode (
  // Tolerance code
  input wire logic [3:0] code_i,
  // Decoded meaning
  output radio_cfg_pkg::preamble_cfg_t cfg_o
);
  import radio_cfg_pkg::*;

  always_comb begin
    cfg_o = '0;
    if (code_i == TOL_DISABLED) begin
      cfg_o.detect_enable = 1'b0;
    end else if (code_i > TOL_ZERO_ERR) begin
      cfg_o.reserved_code = 1'b1;
    end else if (code_i < TOL_FOUR_ERR) begin
      // Detection still runs so a poor setting degrades rather than stops.
      cfg_o.detect_enable = 1'b1;
      cfg_o.not_recommended = 1'b1;
      cfg_o.err_pairs = 3'h4;
    end else begin
      cfg_o.detect_enable = 1'b1;
      cfg_o.err_pairs = 3'(TOL_ZERO_ERR - code_i);
    end
  end

endmodule : preamble_tolerance_decode
`default_nettype wire

// >>> core/radio_cfg_pkg.sv
package radio_cfg_pkg;

  // ==========================================================
  // Register port geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [9:0] OFF_PHASE_TRIM = 10'h118;
  localparam logic [9:0] OFF_AMPL_TRIM = 10'h119;
  localparam logic [9:0] OFF_OP_OPTIONS = 10'h11A;
  localparam logic [9:0] OFF_PREAMBLE_TOL = 10'h11B;
  localparam logic [9:0] OFF_CODING = 10'h11C;
  localparam logic [9:0] OFF_PREAMBLE_BYTES = 10'h11D;
  localparam logic [9:0] OFF_CRC_LO = 10'h11E;
  localparam logic [9:0] OFF_CRC_HI = 10'h11F;
  localparam logic [9:0] OFF_LOCK_TIME_LO = 10'h13E;
  localparam logic [9:0] OFF_LOCK_TIME_HI = 10'h13F;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ==========================================================
  // Field positions in the operation options register
  localparam int BIT_SMART_WAKE = 7;
  localparam int BIT_IF_CAL = 6;
  localparam int BIT_LP_QUALIFY = 5;
  localparam int BIT_AUTO_RX = 4;
  localparam int BIT_AUTO_TX = 3;
  localparam int BIT_CUSTOM_LOCK = 2;
  localparam int BIT_EXT_RX_AMP = 1;
  localparam int BIT_EXT_TX_AMP = 0;

  // ==========================================================
  // Field positions in the symbol coding register
  localparam int BIT_MANCHESTER = 6;
  localparam int BIT_PROG_CRC = 5;
  localparam int BIT_EIGHT_TEN = 4;
  localparam int BIT_WHITENING = 3;
  localparam int SYM_WIDTH_MSB = 2;
  localparam logic [2:0] SYM_WIDTH_8 = 3'h0;
  localparam logic [2:0] SYM_WIDTH_10 = 3'h1;

  // ==========================================================
  // Preamble tolerance codes
  localparam logic [3:0] TOL_DISABLED = 4'h0;
  localparam logic [3:0] TOL_FOUR_ERR = 4'h8;
  localparam logic [3:0] TOL_ZERO_ERR = 4'hC;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    sleep_state,
    off_state,
    ready_state,
    receive_state,
    transmit_state
  } radio_state_t;

  typedef struct packed {
    logic detect_enable;
    logic [2:0] err_pairs;
    logic not_recommended;
    logic reserved_code;
  } preamble_cfg_t;

  typedef struct packed {
    logic smart_wake_enable;
    logic low_power_signal_qualify;
    logic manchester_enable;
    logic programmable_crc_select;
    logic eight_ten_enable;
    logic whitening_enable;
    logic symbol_10bit;
    logic symbol_reserved;
    logic sync_lock_allowed;
    logic [10:0] preamble_bits;
    logic [6:0] phase_trim;
    logic [6:0] amplitude_trim;
  } radio_cfg_t;

endpackage : radio_cfg_pkg

// >>> core/radio_mode_packet_config.sv
// Notes on behaviour
// - Hold a 7-bit I/Q phase trim in bits 6:0; bit 7 reserved.
// - Hold a 7-bit I/Q amplitude trim in bits 6:0; bit 7 reserved.
// - Smart wake is on exactly while its enable bit is one.
// - Request IF filter calibration on off-to-ready moves when enabled.
// - Low-power signal qualification applies only while its bit is one.
// - In packet mode, turn to receive after a transmission when enabled.
// - In packet mode, turn to transmit after a valid reception when enabled.
// - Custom lock time from two registers when enabled, else built-in default.
// - Receive amplifier pin high in receive, low elsewhere awake, off when disabled.
// - Transmit amplifier pin high in transmit, low elsewhere awake, off when disabled.
// - Decode preamble tolerance: 12 none, 11..8 one to four, 0 off.
// - Manchester coding applies only while its enable bit is one.
// - Programmable CRC when selected, built-in CRC otherwise.
// - 8b/10b coding applies only while its enable bit is one.
// - Whitening applies only while its enable bit is one.
// - Symbol width code 0 is 8 bits, 1 is 10 bits, rest reserved.
// - Preamble length counts bytes, eight bits per unit.
// - Frequency loop may lock on sync only when preamble detection is off.
// - CRC polynomial is 16 bits over a low and a high byte register.
`timescale 1ns/1ps
`default_nettype none

module radio_mode_packet_config #(
  parameter logic [15:0] DEFAULT_LOCK_TIME = 16'h0100
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [radio_cfg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [radio_cfg_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [radio_cfg_pkg::DATA_W-1:0] rdata_o,
  // Radio state machine
  input wire radio_cfg_pkg::radio_state_t radio_state_i,
  input wire logic packet_mode_i,
  input wire logic tx_done_i,
  input wire logic rx_valid_i,
  output logic if_cal_req_o,
  output logic auto_rx_req_o,
  output logic auto_tx_req_o,
  // Settings for neighbouring blocks
  output radio_cfg_pkg::radio_cfg_t cfg_o,
  output radio_cfg_pkg::preamble_cfg_t preamble_cfg_o,
  output logic [15:0] lock_time_o,
  output logic [15:0] crc_polynomial_o,
  // External amplifier control pins
  output logic lna_o,
  output logic lna_oe_o,
  output logic pa_o,
  output logic pa_oe_o
);
  import radio_cfg_pkg::*;

  // ==========================================================
  // Register storage
  logic [7:0] phase_trim;
  logic [7:0] ampl_trim;
  logic [7:0] op_options;
  logic [7:0] preamble_tol;
  logic [7:0] coding;
  logic [7:0] preamble_bytes;
  logic [7:0] crc_lo;
  logic [7:0] crc_hi;
  logic [7:0] lock_lo;
  logic [7:0] lock_hi;
  logic [7:0] next_rdata;
  radio_state_t prev_state;
  preamble_cfg_t pre_dec;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
    hit = (a == off);
  endfunction : hit

  // Reserved bits are stored as written so software sees its own value back.
  // phase trim store
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_trim <= RST_REG;
    end else if (we_i && hit(addr_i, OFF_PHASE_TRIM)) begin
      phase_trim <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ampl_trim <= RST_REG;
    end else if (we_i && hit(addr_i, OFF_AMPL_TRIM)) begin
      ampl_trim <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_options <= RST_REG;
      preamble_tol <= RST_REG;
      coding <= RST_REG;
      preamble_bytes <= RST_REG;
    end else if (we_i) begin
      if (hit(addr_i, OFF_OP_OPTIONS)) begin
        op_options <= wdata_i;
      end
      if (hit(addr_i, OFF_PREAMBLE_TOL)) begin
        preamble_tol <= wdata_i;
      end
      if (hit(addr_i, OFF_CODING)) begin
        coding <= wdata_i;
      end
      if (hit(addr_i, OFF_PREAMBLE_BYTES)) begin
        preamble_bytes <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      crc_lo <= RST_REG;
      crc_hi <= RST_REG;
    end else if (we_i) begin
      if (hit(addr_i, OFF_CRC_LO)) begin
        crc_lo <= wdata_i;
      end
      if (hit(addr_i, OFF_CRC_HI)) begin
        crc_hi <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_lo <= RST_REG;
      lock_hi <= RST_REG;
    end else if (we_i) begin
      if (hit(addr_i, OFF_LOCK_TIME_LO)) begin
        lock_lo <= wdata_i;
      end
      if (hit(addr_i, OFF_LOCK_TIME_HI)) begin
        lock_hi <= wdata_i;
      end
    end
  end

  // ==========================================================
  // Read path
  // readback mux
  always_comb begin
    case (addr_i)
      OFF_PHASE_TRIM: next_rdata = phase_trim;
      OFF_AMPL_TRIM: next_rdata = ampl_trim;
      OFF_OP_OPTIONS: next_rdata = op_options;
      OFF_PREAMBLE_TOL: next_rdata = preamble_tol;
      OFF_CODING: next_rdata = coding;
      OFF_PREAMBLE_BYTES: next_rdata = preamble_bytes;
      OFF_CRC_LO: next_rdata = crc_lo;
      OFF_CRC_HI: next_rdata = crc_hi;
      OFF_LOCK_TIME_LO: next_rdata = lock_lo;
      OFF_LOCK_TIME_HI: next_rdata = lock_hi;
      default: next_rdata = RST_RDATA;
    endcase
  end

  // Read data stand for one cycle only, so a stale value is never mistaken.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= RST_RDATA;
    end else if (re_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= RST_RDATA;
    end
  end

  // ==========================================================
  // Decoded settings
  preamble_tolerance_decode u_pre_dec (
    .code_i(preamble_tol[3:0]),
    .cfg_o(pre_dec)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      preamble_cfg_o <= '0;
    end else begin
      preamble_cfg_o <= pre_dec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.smart_wake_enable <= op_options[BIT_SMART_WAKE];
      cfg_o.low_power_signal_qualify <= op_options[BIT_LP_QUALIFY];
      cfg_o.manchester_enable <= coding[BIT_MANCHESTER];
      cfg_o.programmable_crc_select <= coding[BIT_PROG_CRC];
      cfg_o.eight_ten_enable <= coding[BIT_EIGHT_TEN];
      cfg_o.whitening_enable <= coding[BIT_WHITENING];
      cfg_o.symbol_10bit <= (coding[SYM_WIDTH_MSB:0] == SYM_WIDTH_10);
      cfg_o.symbol_reserved <= (coding[SYM_WIDTH_MSB:0] != SYM_WIDTH_8) &&
                               (coding[SYM_WIDTH_MSB:0] != SYM_WIDTH_10);
      cfg_o.sync_lock_allowed <= (preamble_tol[3:0] == TOL_DISABLED);
      cfg_o.preamble_bits <= {preamble_bytes, 3'b000};
      cfg_o.phase_trim <= phase_trim[6:0];
      cfg_o.amplitude_trim <= ampl_trim[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_time_o <= DEFAULT_LOCK_TIME;
    end else if (op_options[BIT_CUSTOM_LOCK]) begin
      lock_time_o <= {lock_hi, lock_lo};
    end else begin
      lock_time_o <= DEFAULT_LOCK_TIME;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      crc_polynomial_o <= {RST_REG, RST_REG};
    end else begin
      crc_polynomial_o <= {crc_hi, crc_lo};
    end
  end

  // ==========================================================
  // State-driven requests
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_state <= sleep_state;
    end else begin
      prev_state <= radio_state_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      if_cal_req_o <= 1'b0;
    end else begin
      if_cal_req_o <= op_options[BIT_IF_CAL] && (prev_state == off_state) &&
                      (radio_state_i == ready_state);
    end
  end

  // Turnarounds exist only in packet mode; in other modes the bits are inert.
  // receive turnaround
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      auto_rx_req_o <= 1'b0;
    end else begin
      auto_rx_req_o <= tx_done_i && packet_mode_i && op_options[BIT_AUTO_RX];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      auto_tx_req_o <= 1'b0;
    end else begin
      auto_tx_req_o <= rx_valid_i && packet_mode_i && op_options[BIT_AUTO_TX];
    end
  end

  // ==========================================================
  // Amplifier pins
  // In sleep the pins are released, since the amplifiers are unpowered then.
  // receive amplifier pin
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lna_o <= 1'b0;
      lna_oe_o <= 1'b0;
    end else begin
      lna_oe_o <= op_options[BIT_EXT_RX_AMP] && (radio_state_i != sleep_state);
      lna_o <= op_options[BIT_EXT_RX_AMP] && (radio_state_i == receive_state);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pa_o <= 1'b0;
      pa_oe_o <= 1'b0;
    end else begin
      pa_oe_o <= op_options[BIT_EXT_TX_AMP] && (radio_state_i != sleep_state);
      pa_o <= op_options[BIT_EXT_TX_AMP] && (radio_state_i == transmit_state);
    end
  end

  // ==========================================================
  // Checks
  a_phase_store: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (we_i && addr_i == OFF_PHASE_TRIM) |=> ##1 cfg_o.phase_trim == $past(wdata_i[6:0], 2))
    else $error("phase trim not applied");

  a_ampl_store: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (we_i && addr_i == OFF_AMPL_TRIM) |=> ##1 cfg_o.amplitude_trim == $past(wdata_i[6:0], 2))
    else $error("amplitude trim not applied");

  a_read_back: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (we_i && addr_i == OFF_CODING) ##1 (re_i && !we_i && addr_i == OFF_CODING)
    |=> rdata_o == $past(wdata_i, 2))
    else $error("readback differs from write");

  a_cal_pulse: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (prev_state == off_state && radio_state_i == ready_state)
    |=> if_cal_req_o == $past(op_options[BIT_IF_CAL]))
    else $error("calibration request wrong");

  a_rx_turn: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (tx_done_i && packet_mode_i) |=> auto_rx_req_o == $past(op_options[BIT_AUTO_RX]))
    else $error("receive turnaround wrong");

  a_tx_turn: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !(rx_valid_i && packet_mode_i) |=> !auto_tx_req_o)
    else $error("spurious transmit turnaround");

  a_lna_pin: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (op_options[BIT_EXT_RX_AMP] && radio_state_i == receive_state) |=> (lna_o && lna_oe_o))
    else $error("receive amplifier pin not high");

  a_pa_pin: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (op_options[BIT_EXT_TX_AMP] && radio_state_i == ready_state) |=> (!pa_o && pa_oe_o))
    else $error("transmit amplifier pin not low");

  a_lock_time: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !op_options[BIT_CUSTOM_LOCK] |=> lock_time_o == DEFAULT_LOCK_TIME)
    else $error("default lock time not used");

  a_pre_bits: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (we_i && addr_i == OFF_PREAMBLE_BYTES) |=> ##1 cfg_o.preamble_bits == 11'($past(wdata_i, 2)) * 11'd8)
    else $error("preamble bit count wrong");

  a_pre_off: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (!srst_i && preamble_tol[3:0] == TOL_DISABLED) |=> (!preamble_cfg_o.detect_enable && cfg_o.sync_lock_allowed))
    else $error("preamble detection not disabled");

  a_sym_width: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (coding[2:0] == SYM_WIDTH_10) |=> (cfg_o.symbol_10bit && !cfg_o.symbol_reserved))
    else $error("symbol width decode wrong");

endmodule : radio_mode_packet_config
`default_nettype wire

// >>> dv/radio_mode_packet_config_tb.sv
`timescale 1ns/1ps
`default_nettype none

module radio_mode_packet_config_tb;
  import radio_cfg_pkg::*;

  // A non-default lock time shows that the parameter really reaches the output.
  localparam logic [15:0] LOCK_DEF = 16'h0123;

  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  radio_state_t radio_state_i = ready_state;
  logic packet_mode_i = 1'b0;
  logic tx_done_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic if_cal_req_o;
  logic auto_rx_req_o;
  logic auto_tx_req_o;
  radio_cfg_t cfg_o;
  preamble_cfg_t preamble_cfg_o;
  logic [15:0] lock_time_o;
  logic [15:0] crc_polynomial_o;
  logic lna_o;
  logic lna_oe_o;
  logic pa_o;
  logic pa_oe_o;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 77560;
  logic [7:0] shadow [0:9];
  logic [9:0] offs [0:9] = '{OFF_PHASE_TRIM, OFF_AMPL_TRIM, OFF_OP_OPTIONS, OFF_PREAMBLE_TOL, OFF_CODING,
    OFF_PREAMBLE_BYTES, OFF_CRC_LO, OFF_CRC_HI, OFF_LOCK_TIME_LO, OFF_LOCK_TIME_HI};

  always #50 clk_i = ~clk_i;

  radio_mode_packet_config #(.DEFAULT_LOCK_TIME(LOCK_DEF)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .radio_state_i(radio_state_i), .packet_mode_i(packet_mode_i),
    .tx_done_i(tx_done_i), .rx_valid_i(rx_valid_i), .if_cal_req_o(if_cal_req_o),
    .auto_rx_req_o(auto_rx_req_o), .auto_tx_req_o(auto_tx_req_o), .cfg_o(cfg_o),
    .preamble_cfg_o(preamble_cfg_o), .lock_time_o(lock_time_o), .crc_polynomial_o(crc_polynomial_o),
    .lna_o(lna_o), .lna_oe_o(lna_oe_o), .pa_o(pa_o), .pa_oe_o(pa_oe_o)
  );

  // ==========================================================
  // Comparison and bus tasks
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr

  // Read data stands for one cycle only, so the following cycle must show zero.
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    chk_val({8'h00, rdata_o}, {8'h00, exp});
    @(posedge clk_i);
    #1;
    chk_val({8'h00, rdata_o}, 16'h0000);
  endtask : rd

  // A read right after a write of the same register must already see the new value.
  task automatic wr_rd(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    chk_val({8'h00, rdata_o}, {8'h00, d});
  endtask : wr_rd

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  // Kind 0 moves off to ready, 1 ends a transmission, 2 ends a reception, 3 moves sleep to ready.
  task automatic cause(input int kind, input logic exp);
    @(posedge clk_i);
    radio_state_i <= (kind == 0) ? off_state : ((kind == 3) ? sleep_state : ready_state);
    tx_done_i <= (kind == 1);
    rx_valid_i <= (kind == 2);
    @(posedge clk_i);
    radio_state_i <= ready_state;
    tx_done_i <= 1'b0;
    rx_valid_i <= 1'b0;
    #1;
    chk_flag(auto_rx_req_o, exp && kind == 1);
    chk_flag(auto_tx_req_o, exp && kind == 2);
    @(posedge clk_i);
    #1;
    chk_flag(if_cal_req_o, exp && kind == 0);
    chk_flag(auto_rx_req_o || auto_tx_req_o, 1'b0);
    @(posedge clk_i);
    #1;
    chk_flag(if_cal_req_o, 1'b0);
  endtask : cause

  function automatic logic [15:0] exp_pairs(input int c);
    return (c >= 8) ? 16'(12 - c) : 16'h0004;
  endfunction : exp_pairs

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(offs[i], RST_REG);
    end
    chk_val(lock_time_o, LOCK_DEF);
    chk_val(crc_polynomial_o, 16'h0000);
    $display("test reset done");
    // Unmapped writes follow the real ones of each round and must disturb nothing.
    for (int n = 0; n < 4; n++) begin
      for (int i = 0; i < 10; i++) begin
        shadow[i] = 8'($random(seed));
        if (i == 2) begin
          shadow[i][2] = n[0];
        end
        wr(offs[i], shadow[i]);
      end
      wr(10'h117, 8'hFF);
      wr(10'h120, 8'($random(seed)));
      for (int i = 0; i < 10; i++) begin
        rd(offs[i], shadow[i]);
      end
      rd(10'h120, 8'h00);
      settle();
      chk_val(16'(cfg_o.phase_trim), 16'(shadow[0][6:0]));
      chk_val(16'(cfg_o.amplitude_trim), 16'(shadow[1][6:0]));
      chk_flag(cfg_o.smart_wake_enable, shadow[2][7]);
      chk_flag(cfg_o.low_power_signal_qualify, shadow[2][5]);
      chk_flag(cfg_o.manchester_enable, shadow[4][6]);
      chk_flag(cfg_o.programmable_crc_select, shadow[4][5]);
      chk_flag(cfg_o.eight_ten_enable, shadow[4][4]);
      chk_flag(cfg_o.whitening_enable, shadow[4][3]);
      chk_val(16'(cfg_o.preamble_bits), {5'h00, shadow[5], 3'h0});
      chk_val(crc_polynomial_o, {shadow[7], shadow[6]});
      chk_val(lock_time_o, shadow[2][2] ? {shadow[9], shadow[8]} : LOCK_DEF);
    end
    $display("test readback done");
    for (int c = 0; c < 16; c++) begin
      wr(OFF_PREAMBLE_TOL, {4'($random(seed)), 4'(c)});
      settle();
      chk_flag(preamble_cfg_o.detect_enable, c >= 1 && c <= 12);
      chk_flag(preamble_cfg_o.not_recommended, c >= 1 && c <= 7);
      chk_flag(preamble_cfg_o.reserved_code, c >= 13);
      chk_flag(cfg_o.sync_lock_allowed, c == 0);
      if (c >= 1 && c <= 12) begin
        chk_val(16'(preamble_cfg_o.err_pairs), exp_pairs(c));
      end
    end
    for (int c = 0; c < 8; c++) begin
      shadow[4] = {5'($random(seed)), 3'(c)};
      wr_rd(OFF_CODING, shadow[4]);
      settle();
      chk_flag(cfg_o.symbol_10bit, c == 1);
      chk_flag(cfg_o.symbol_reserved, c >= 2);
    end
    $display("test decode done");
    for (int k = 0; k < 4; k++) begin
      packet_mode_i <= k[1];
      wr(OFF_OP_OPTIONS, k[0] ? 8'h58 : 8'h00);
      cause(0, k[0]);
      cause(1, k[0] && k[1]);
      cause(2, k[0] && k[1]);
      cause(3, 1'b0);
    end
    $display("test turnaround done");
    for (int e = 0; e < 4; e++) begin
      wr(OFF_OP_OPTIONS, 8'(e));
      for (int s = 0; s < 5; s++) begin
        radio_state_i <= radio_state_t'(s);
        settle();
        chk_flag(lna_oe_o, e[1] && s != 0);
        chk_flag(pa_oe_o, e[0] && s != 0);
        chk_flag(lna_o, e[1] && s == 3);
        chk_flag(pa_o, e[0] && s == 4);
      end
    end
    $display("test amp pins done");
    // A custom lock time in force before reset shows that reset really brings back the default.
    wr(OFF_LOCK_TIME_LO, 8'h5A);
    wr(OFF_LOCK_TIME_HI, 8'hA5);
    wr(OFF_OP_OPTIONS, 8'h04);
    settle();
    chk_val(lock_time_o, 16'hA55A);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(OFF_CRC_HI, RST_REG);
    chk_val(lock_time_o, LOCK_DEF);
    chk_val(crc_polynomial_o, 16'h0000);
    $display("test second reset done");
    give_verdict();
  end

endmodule : radio_mode_packet_config_tb

`default_nettype wire
